// File: verilog/wdt_cfg_bank.sv
/*
 * configuration register bank for the watchdog logical device.
 * assumes indexed configuration reads and writes already decoded for this
 * logical device by the host interface; all on one clock.
 */
`timescale 1ns/1ns
module watchdog_cfg_bank (
    input wire logic clk_i, // 125 MHz clock
    input wire logic reset_i, // synchronous, active high
    input watchdog_cfg_pkg::cfg_req_s req_i, // indexed configuration access
    output logic [7:0] rdata_o, // read data, valid cycle after rd
    input wire logic alarm_n_i, // timer unit output, active low
    output logic timer_regs_enable_o, // timer registers reachable
    output logic timer_clock_enable_o, // timer unit clock runs
    output logic [15:0] base_address_o, // timer I/O base address
    output logic [3:0] irq_number_o, // routed interrupt number
    output logic wake_enable_o, // wake-up on interrupt
    output logic irq_type_o, // interrupt type bit 1
    output watchdog_cfg_pkg::pin_s pin_o // watchdog output pin
);
    import watchdog_cfg_pkg::*;

    typedef struct packed {
        logic [7:0] activate;
        logic [7:0] base_high;
        logic [7:0] base_low;
        logic [7:0] irq_num;
        logic [7:0] irq_type;
        logic [7:0] timer_config;
        logic [7:0] rdata;
    } bank_s;

    bank_s bank_q;
    bank_s bank_d;
    logic active;

    // -------------------------------------------------------------
    // register writes and reads
    // -------------------------------------------------------------
    // read-only bits keep their value through any write
    always_comb begin
        bank_d = bank_q;
        if (req_i.wr) begin
            unique case (req_i.index)
                IDX_ACTIVATE: bank_d.activate = req_i.wdata;
                IDX_BASE_HIGH: bank_d.base_high = req_i.wdata;
                IDX_BASE_LOW: bank_d.base_low = req_i.wdata & BASE_LOW_RW_MASK;
                IDX_IRQ_NUM: bank_d.irq_num = req_i.wdata;
                IDX_IRQ_TYPE: bank_d.irq_type = (RST_IRQ_TYPE & ~IRQ_TYPE_RW_MASK)
                    | (req_i.wdata & IRQ_TYPE_RW_MASK);
                IDX_TIMER_CONFIG: bank_d.timer_config = req_i.wdata & TIMER_CONFIG_RW_MASK;
                default: bank_d = bank_q;
            endcase
        end
        if (req_i.rd) begin
            unique case (req_i.index)
                IDX_ACTIVATE: bank_d.rdata = bank_q.activate;
                IDX_BASE_HIGH: bank_d.rdata = bank_q.base_high;
                IDX_BASE_LOW: bank_d.rdata = bank_q.base_low;
                IDX_IRQ_NUM: bank_d.rdata = bank_q.irq_num;
                IDX_IRQ_TYPE: bank_d.rdata = bank_q.irq_type;
                IDX_DMA_FIRST: bank_d.rdata = VAL_NO_DMA;
                IDX_DMA_SECOND: bank_d.rdata = VAL_NO_DMA;
                IDX_TIMER_CONFIG: bank_d.rdata = bank_q.timer_config;
                default: bank_d.rdata = VAL_UNMAPPED;
            endcase
        end
    end

    // state register with documented reset values
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bank_q <= '{activate: RST_ACTIVATE, base_high: RST_BASE_HIGH,
                base_low: RST_BASE_LOW, irq_num: RST_IRQ_NUM,
                irq_type: RST_IRQ_TYPE, timer_config: RST_TIMER_CONFIG,
                rdata: VAL_UNMAPPED};
        end else begin
            bank_q <= bank_d;
        end
    end

    // -------------------------------------------------------------
    // outputs steering the timer unit
    // -------------------------------------------------------------
    assign active = bank_q.activate[ACT_BIT];
    assign timer_regs_enable_o = active;
    assign timer_clock_enable_o = bank_q.timer_config[CFG_POWER_BIT];
    assign base_address_o = {bank_q.base_high, bank_q.base_low};
    assign irq_number_o = bank_q.irq_num[IRQ_NUM_LSB +: IRQ_NUM_W];
    assign wake_enable_o = bank_q.irq_num[WAKE_BIT];
    assign irq_type_o = bank_q.irq_type[1];
    assign rdata_o = bank_q.rdata;

    // pin stage: low power forces high, float when inactive and float bit set
    watchdog_pin_driver u_pin (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .alarm_n_i(alarm_n_i),
        .low_power_i(~bank_q.timer_config[CFG_POWER_BIT]),
        .float_i(bank_q.timer_config[CFG_FLOAT_BIT] & ~active),
        .push_pull_i(bank_q.timer_config[CFG_PUSHPULL_BIT]),
        .pullup_i(bank_q.timer_config[CFG_PULLUP_BIT]),
        .pin_o(pin_o)
    );

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    property p_act_reset;
        $fell(reset_i) |-> !timer_regs_enable_o && base_address_o == 16'h0000;
    endproperty
    a_act_reset: assert property (p_act_reset)
        else $error("activate not cleared by reset");

    property p_act_gate;
        req_i.wr && req_i.index == IDX_ACTIVATE |=> timer_regs_enable_o == $past(req_i.wdata[0]);
    endproperty
    a_act_gate: assert property (p_act_gate)
        else $error("activate bit does not gate timer registers");

    property p_base_high;
        req_i.wr && req_i.index == IDX_BASE_HIGH ##1 req_i.rd && req_i.index == IDX_BASE_HIGH
            |=> rdata_o == $past(req_i.wdata, 2);
    endproperty
    a_base_high: assert property (p_base_high)
        else $error("base high byte not stored");

    property p_base_low_zero;
        base_address_o[1:0] == 2'b00;
    endproperty
    a_base_low_zero: assert property (p_base_low_zero)
        else $error("base address low bits not zero");

    property p_irq_route;
        req_i.wr && req_i.index == IDX_IRQ_NUM
            |=> irq_number_o == $past(req_i.wdata[3:0]) && wake_enable_o == $past(req_i.wdata[4]);
    endproperty
    a_irq_route: assert property (p_irq_route)
        else $error("interrupt number or wake enable wrong");

    property p_type_fixed;
        req_i.rd && req_i.index == IDX_IRQ_TYPE |=> rdata_o[7:2] == 6'h00 && rdata_o[0];
    endproperty
    a_type_fixed: assert property (p_type_fixed)
        else $error("interrupt type read-only bits changed");

    property p_no_dma;
        req_i.rd && (req_i.index == IDX_DMA_FIRST || req_i.index == IDX_DMA_SECOND)
            |=> rdata_o == VAL_NO_DMA;
    endproperty
    a_no_dma: assert property (p_no_dma)
        else $error("dma report not 04h");

    property p_cfg_reset;
        $fell(reset_i) |-> timer_clock_enable_o && !pin_o.pullup_en;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset)
        else $error("configuration reset value wrong");

    property p_low_power;
        !timer_clock_enable_o && $stable(timer_clock_enable_o) |=> pin_o.out;
    endproperty
    a_low_power: assert property (p_low_power)
        else $error("output not held high in low power");

    property p_float;
        bank_q.timer_config[CFG_FLOAT_BIT] && !active && $stable(bank_q.timer_config)
            && $stable(active) |=> pin_o.oe_n;
    endproperty
    a_float: assert property (p_float)
        else $error("pin not floated while inactive");

    // -------------------------------------------------------------
    // write effects, fixed bits and held outputs
    // -------------------------------------------------------------
    property p_base_low_write;
        req_i.wr && req_i.index == IDX_BASE_LOW
            |=> base_address_o[7:2] == $past(req_i.wdata[7:2]);
    endproperty
    a_base_low_write: assert property (p_base_low_write)
        else $error("base low byte upper bits not stored");

    property p_type_write;
        req_i.wr && req_i.index == IDX_IRQ_TYPE |=> irq_type_o == $past(req_i.wdata[1]);
    endproperty
    a_type_write: assert property (p_type_write)
        else $error("interrupt type bit 1 not stored");

    property p_power_write;
        req_i.wr && req_i.index == IDX_TIMER_CONFIG
            |=> timer_clock_enable_o == $past(req_i.wdata[CFG_POWER_BIT]);
    endproperty
    a_power_write: assert property (p_power_write)
        else $error("power bit does not steer timer clock");

    // a write to a report register must leave every steering output alone
    property p_ro_write;
        req_i.wr && (req_i.index == IDX_DMA_FIRST || req_i.index == IDX_DMA_SECOND)
            |=> $stable(base_address_o) && $stable(irq_number_o) && $stable(wake_enable_o)
                && $stable(irq_type_o) && $stable(timer_regs_enable_o)
                && $stable(timer_clock_enable_o);
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("write to report register changed the bank");

    property p_cfg_reserved;
        req_i.rd && req_i.index == IDX_TIMER_CONFIG |=> rdata_o[7:4] == 4'h0;
    endproperty
    a_cfg_reserved: assert property (p_cfg_reserved)
        else $error("reserved configuration bits not zero");

    // pull-up request reaches the pin one cycle after the register
    property p_pullup_follow;
        1'b1 |=> pin_o.pullup_en == $past(bank_q.timer_config[CFG_PULLUP_BIT]);
    endproperty
    a_pullup_follow: assert property (p_pullup_follow)
        else $error("pull-up enable does not follow configuration");

    // read data stands until the next read strobe
    property p_rdata_hold;
        !req_i.rd |=> $stable(rdata_o);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a read");

endmodule

// File: verilog/wdt_cfg_pkg.sv
/*
 * constants and carrier types for the watchdog logical device configuration bank.
 * assumes one 125 MHz clock and a synchronous active-high reset.
 */
package watchdog_cfg_pkg;

    // -------------------------------------------------------------
    // register indices
    // -------------------------------------------------------------
    localparam logic [7:0] IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
    localparam logic [7:0] IDX_BASE_LOW = 8'h61;
    localparam logic [7:0] IDX_IRQ_NUM = 8'h70;
    localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
    localparam logic [7:0] IDX_DMA_FIRST = 8'h74;
    localparam logic [7:0] IDX_DMA_SECOND = 8'h75;
    localparam logic [7:0] IDX_TIMER_CONFIG = 8'hf0;

    // -------------------------------------------------------------
    // reset and fixed values
    // -------------------------------------------------------------
    localparam logic [7:0] RST_ACTIVATE = 8'h00;
    localparam logic [7:0] RST_BASE_HIGH = 8'h00;
    localparam logic [7:0] RST_BASE_LOW = 8'h00;
    localparam logic [7:0] RST_IRQ_NUM = 8'h00;
    localparam logic [7:0] RST_IRQ_TYPE = 8'h03;
    localparam logic [7:0] VAL_NO_DMA = 8'h04;
    localparam logic [7:0] RST_TIMER_CONFIG = 8'h02;
    localparam logic [7:0] VAL_UNMAPPED = 8'h00;

    // -------------------------------------------------------------
    // field positions and masks
    // -------------------------------------------------------------
    localparam int ACT_BIT = 0;
    localparam logic [7:0] BASE_LOW_RW_MASK = 8'hfc;
    localparam logic [7:0] IRQ_TYPE_RW_MASK = 8'h02;
    localparam logic [7:0] TIMER_CONFIG_RW_MASK = 8'h0f;
    localparam int IRQ_NUM_LSB = 0;
    localparam int IRQ_NUM_W = 4;
    localparam int WAKE_BIT = 4;
    localparam int CFG_FLOAT_BIT = 0;
    localparam int CFG_POWER_BIT = 1;
    localparam int CFG_PULLUP_BIT = 2;
    localparam int CFG_PUSHPULL_BIT = 3;

    // configuration access from the host interface
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] index;
        logic [7:0] wdata;
    } cfg_req_s;

    // watchdog output pin, three signals
    typedef struct packed {
        logic out;
        logic oe_n;
        logic pullup_en;
    } pin_s;

endpackage

// File: verilog/wdt_pin_driver.sv
/*
 * drives the active-low watchdog output pin from the timer unit's signal.
 * assumes the timer signal is on the same clock; oe_n low means the pin is driven.
 */
`timescale 1ns/1ns
module watchdog_pin_driver (
    input wire logic clk_i, // 125 MHz clock
    input wire logic reset_i, // synchronous, active high
    input wire logic alarm_n_i, // timer output, low when firing
    input wire logic low_power_i, // hold output inactive
    input wire logic float_i, // release the pin entirely
    input wire logic push_pull_i, // 1 push-pull, 0 open-drain
    input wire logic pullup_i, // internal pull-up request
    output watchdog_cfg_pkg::pin_s pin_o // pin out, enable and pull-up
);
    import watchdog_cfg_pkg::*;

    pin_s state_q;
    pin_s state_d;
    logic level;

    // -------------------------------------------------------------
    // output pin stage
    // -------------------------------------------------------------
    // level held high in low power; open-drain drives only the low level
    always_comb begin
        level = low_power_i ? 1'b1 : alarm_n_i;
        state_d.out = level;
        state_d.pullup_en = pullup_i;
        if (float_i) begin
            state_d.oe_n = 1'b1;
        end else if (push_pull_i) begin
            state_d.oe_n = 1'b0;
        end else begin
            state_d.oe_n = level;
        end
    end

    // register the pin so the output comes from flip-flops
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= '{out: 1'b1, oe_n: 1'b1, pullup_en: 1'b0};
        end else begin
            state_q <= state_d;
        end
    end

    assign pin_o = state_q;

endmodule

// File: testbench/cfg_host_model.sv
/*
 * host model issuing indexed configuration reads and writes to the bank.
 * assumes the bench clock; requests change only at the falling edge.
 */
`timescale 1ns/1ns
module cfg_host_model (
    input wire logic clk_i, // bench clock
    input wire logic [7:0] rdata_i, // read data from the bank
    output watchdog_cfg_pkg::cfg_req_s req_o // access strobes, index and data
);
    import watchdog_cfg_pkg::*;
    // idle bus from time zero
    initial begin
        req_o = '0;
    end
    // one-cycle write strobe, then one idle cycle
    task automatic cfg_write(input logic [7:0] idx, input logic [7:0] val);
        @(negedge clk_i);
        req_o = '{wr: 1'b1, rd: 1'b0, index: idx, wdata: val};
        @(negedge clk_i);
        req_o = '0;
    endtask
    // read strobe; data has landed by the next falling edge
    task automatic cfg_read(input logic [7:0] idx, output logic [7:0] val);
        @(negedge clk_i);
        req_o = '{wr: 1'b0, rd: 1'b1, index: idx, wdata: 8'h00};
        @(negedge clk_i);
        req_o = '0;
        val = rdata_i;
    endtask
    // write, then read the same index on the very next cycle
    task automatic cfg_write_read(input logic [7:0] idx, input logic [7:0] wval,
                                  output logic [7:0] rval);
        @(negedge clk_i);
        req_o = '{wr: 1'b1, rd: 1'b0, index: idx, wdata: wval};
        @(negedge clk_i);
        req_o = '{wr: 1'b0, rd: 1'b1, index: idx, wdata: 8'h00};
        @(negedge clk_i);
        req_o = '0;
        rval = rdata_i;
    endtask
endmodule

// File: testbench/watchdog_logical_device_config_test.sv
/*
 * self-checking bench for the watchdog configuration bank.
 * assumes the host model drives the request port; the bench drives the timer signal.
 */
`timescale 1ns/1ns
`define CHK(act_v, exp_v) begin n_compared++; if ((act_v) !== (exp_v)) begin bad_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, act_v, exp_v); end end
module watchdog_logical_device_config_test;
    import watchdog_cfg_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic alarm_n = 1'b1;
    cfg_req_s req;
    logic [7:0] rdata;
    logic regs_en, clk_en, wake, irq_type;
    logic [15:0] base;
    logic [3:0] irq_num;
    pin_s pin;
    int bad_count = 0;
    int n_compared = 0;
    logic [7:0] v;
    // index table with reset, after-ones and after-zeros read values
    logic [7:0] idx [9] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75, 8'hf0, 8'h55};
    logic [7:0] rst [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h04, 8'h04, 8'h02, 8'h00};
    logic [7:0] one [9] = '{8'hff, 8'hff, 8'hfc, 8'hff, 8'h03, 8'h04, 8'h04, 8'h0f, 8'h00};
    logic [7:0] zer [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04, 8'h04, 8'h00, 8'h00};

    // 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end

    cfg_host_model host (.clk_i(clk), .rdata_i(rdata), .req_o(req));

    watchdog_cfg_bank uut (
        .clk_i(clk), .reset_i(reset), .req_i(req), .rdata_o(rdata),
        .alarm_n_i(alarm_n), .timer_regs_enable_o(regs_en),
        .timer_clock_enable_o(clk_en), .base_address_o(base),
        .irq_number_o(irq_num), .wake_enable_o(wake), .irq_type_o(irq_type),
        .pin_o(pin)
    );

    // counts, verdict, end of run
    task automatic give_verdict();
        $display("compared %0d, mismatched %0d", n_compared, bad_count);
        if (n_compared > 0 && bad_count == 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // write every index with one value, then read all back
    task automatic fill_check(input logic [7:0] val, input logic [7:0] exp [9]);
        for (int i = 0; i < 9; i++) begin
            host.cfg_write(idx[i], val);
        end
        for (int i = 0; i < 9; i++) begin
            host.cfg_read(idx[i], v);
            `CHK(v, exp[i])
        end
    endtask

    // set activate and config, drive the timer signal, look at {out, oe_n}
    task automatic pin_case(input logic [7:0] act, input logic [7:0] cfg, input logic al,
                            input logic [1:0] exp);
        host.cfg_write(8'h30, act);
        host.cfg_write(8'hf0, cfg);
        alarm_n = al;
        repeat (2) @(negedge clk);
        `CHK({pin.out, pin.oe_n}, exp)
    endtask

    // watchdog against a hang
    initial begin
        #40000;
        bad_count++;
        give_verdict();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(negedge clk);
        reset = 1'b0;
        for (int i = 0; i < 9; i++) begin
            host.cfg_read(idx[i], v);
            `CHK(v, rst[i])
        end
        `CHK(regs_en, 1'b0)
        `CHK(clk_en, 1'b1)
        $display("reset values done");
        fill_check(8'hff, one);
        `CHK(base, 16'hfffc)
        `CHK({wake, irq_num}, 5'h1f)
        `CHK(irq_type, 1'b1)
        `CHK(regs_en, 1'b1)
        fill_check(8'h00, zer);
        `CHK(base, 16'h0000)
        `CHK(irq_type, 1'b0)
        `CHK(regs_en, 1'b0)
        `CHK(clk_en, 1'b0)
        $display("write and read back done");
        pin_case(8'h01, 8'h0a, 1'b0, 2'b00);
        pin_case(8'h01, 8'h0a, 1'b1, 2'b10);
        pin_case(8'h01, 8'h02, 1'b0, 2'b00);
        pin_case(8'h01, 8'h02, 1'b1, 2'b11);
        pin_case(8'h01, 8'h08, 1'b0, 2'b10);
        `CHK(clk_en, 1'b0)
        pin_case(8'h00, 8'h0b, 1'b0, 2'b01);
        pin_case(8'h00, 8'h0a, 1'b0, 2'b00);
        pin_case(8'h01, 8'h0b, 1'b0, 2'b00);
        host.cfg_write(8'hf0, 8'h06);
        repeat (2) @(negedge clk);
        `CHK(pin.pullup_en, 1'b1)
        $display("pin control done");
        // back-to-back write and read of the base address bytes
        host.cfg_write_read(8'h60, 8'h5a, v);
        `CHK(v, 8'h5a)
        host.cfg_write_read(8'h61, 8'ha7, v);
        `CHK(v, 8'ha4)
        `CHK(base, 16'h5aa4)
        $display("back to back done");
        // second reset in mid-run restores the reset values
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        `CHK(pin.pullup_en, 1'b0)
        `CHK(regs_en, 1'b0)
        `CHK(base, 16'h0000)
        `CHK(clk_en, 1'b1)
        host.cfg_read(8'hf0, v);
        `CHK(v, 8'h02)
        host.cfg_read(8'h71, v);
        `CHK(v, 8'h03)
        $display("second reset done");
        give_verdict();
    end
endmodule
